// ---- design/tt_timer.sv ----
// module: sixteen-bit timer two with capture, reload, baud and clock out
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 16-bit count advances only while running
// - source bit picks system clock or pin
// - overflow flag only when no baud select
// - trigger falling edge sets event flag if enabled, except in up/down counting
// - bits 5/4 pick receive/transmit clock
// - clock output enable drives count pin when the source bit picks system clock
// - updown enable resets zero, pin picks direction
// - mode decode from run, output, baud, capture
// - capture mode copies count on trigger edge
// - reload mode reloads on overflow, sets flag
// - trigger edge also reloads in reload mode
// - updown: pin high counts up, reload
// - down count underflows at reload value
// - updown toggles event flag, no interrupt
// - baud mode reloads silently, feeds serial
// - baud mode trigger sets flag, no reload
// - serial rate from overflow rate
// - clock out with baud toggles pin silently
// - plain clock out sets overflow flag
// - both flags share one interrupt request
// - software sets flags; only software clears, except the updown event flag toggle
module tt_timer
    import tt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire tt_pkg::tt_bus_t bus,
    output logic [7:0] rdata,
    input wire logic count_pin_in,
    input wire logic trigger_pin,
    output tt_pkg::tt_link_t link,
    output logic timer_irq
);
    import tt_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] timer_two_control;
    logic [1:0] timer_two_mode;
    logic [15:0] reload_capture;
    logic [15:0] count;
    logic clk_out;

    logic overflow_flag;
    logic ext_event_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic ext_trigger_enable;
    logic run_control;
    logic count_source_select;
    logic capture_not_reload;
    logic clock_out_enable;
    logic updown_enable;

    assign overflow_flag = timer_two_control[BIT_OVF];
    assign ext_event_flag = timer_two_control[BIT_EXF];
    assign rx_baud_select = timer_two_control[BIT_RCLK];
    assign tx_baud_select = timer_two_control[BIT_TX_BAUD_SELECT];
    assign ext_trigger_enable = timer_two_control[BIT_EXEN];
    assign run_control = timer_two_control[BIT_RUN];
    assign count_source_select = timer_two_control[BIT_CSRC];
    assign capture_not_reload = timer_two_control[BIT_CAP];
    assign clock_out_enable = timer_two_mode[BIT_OE];
    assign updown_enable = timer_two_mode[BIT_UPDOWN_ENABLE];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cnt_level;
    logic cnt_fall;
    logic trg_level;
    logic trg_fall;

    tt_edge_sync u_cnt_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in(count_pin_in),
        .level(cnt_level),
        .fall(cnt_fall)
    );

    tt_edge_sync u_trg_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in(trigger_pin),
        .level(trg_level),
        .fall(trg_fall)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    tt_mode_t mode;
    logic baud_any;

    assign baud_any = rx_baud_select | tx_baud_select;

    always_comb begin
        if (!run_control) begin
            mode = TT_STOP;
        end else if (clock_out_enable && !count_source_select) begin
            mode = TT_CLKOUT;
        end else if (baud_any) begin
            mode = TT_BAUD;
        end else if (capture_not_reload) begin
            mode = TT_CAPTURE;
        end else begin
            mode = TT_RELOAD;
        end
    end

    // ------------------------------------------------------------
    // count engine
    // ------------------------------------------------------------
    logic tick;
    logic updown_active;
    logic count_down;
    logic wrap_up;
    logic wrap_down;
    logic wrap;
    logic trig_reload;
    logic trig_capture;
    logic trig_flag;
    logic ovf_set;
    logic [15:0] next_count;

    // clock-out mode always counts the system clock
    assign tick = (mode != TT_STOP) &&
                  ((count_source_select && mode != TT_CLKOUT) ? cnt_fall : 1'b1);
    assign updown_active = (mode == TT_RELOAD) && updown_enable;
    assign count_down = updown_active && !trg_level;
    assign wrap_up = tick && !count_down && (count == COUNT_MAX);
    assign wrap_down = tick && count_down && (count == reload_capture);
    assign wrap = wrap_up || wrap_down;
    assign trig_flag = ext_trigger_enable && trg_fall && !updown_active;
    assign trig_reload = trig_flag && (mode == TT_RELOAD);
    assign trig_capture = trig_flag && (mode == TT_CAPTURE);
    // overflow flag suppressed whenever a baud select is set
    assign ovf_set = wrap && !baud_any;

    always_comb begin
        next_count = count;
        if (wrap_down) begin
            next_count = COUNT_MAX;
        end else if (wrap_up && mode != TT_CAPTURE) begin
            next_count = reload_capture;
        end else if (trig_reload) begin
            next_count = reload_capture;
        end else if (tick) begin
            next_count = count_down ? count - 16'h0001 : count + 16'h0001;
        end
    end

    logic wr_cl;
    logic wr_ch;
    logic wr_rl;
    logic wr_rh;
    logic wr_ctl;
    logic wr_mod;

    assign wr_cl = bus.wr && (bus.addr == ADDR_COUNT_LOW);
    assign wr_ch = bus.wr && (bus.addr == ADDR_COUNT_HIGH);
    assign wr_rl = bus.wr && (bus.addr == ADDR_RCAP_LOW);
    assign wr_rh = bus.wr && (bus.addr == ADDR_RCAP_HIGH);
    assign wr_ctl = bus.wr && (bus.addr == ADDR_CONTROL);
    assign wr_mod = bus.wr && (bus.addr == ADDR_MODE);

    // software writes take over the engine; stopping first is the user's job
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= {RESET_BYTE, RESET_BYTE};
        end else begin
            count <= next_count;
            if (wr_cl) begin
                count[7:0] <= bus.wdata;
            end
            if (wr_ch) begin
                count[15:8] <= bus.wdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reload_capture <= {RESET_BYTE, RESET_BYTE};
        end else begin
            if (trig_capture) begin
                reload_capture <= count;
            end else begin
                if (wr_rl) begin
                    reload_capture[7:0] <= bus.wdata;
                end
                if (wr_rh) begin
                    reload_capture[15:8] <= bus.wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // control and mode registers, flags
    // ------------------------------------------------------------
    logic next_ovf;
    logic next_exf;

    always_comb begin
        next_ovf = wr_ctl ? bus.wdata[BIT_OVF] : overflow_flag;
        next_exf = wr_ctl ? bus.wdata[BIT_EXF] : ext_event_flag;
        if (ovf_set) begin
            next_ovf = 1'b1;
        end
        if (updown_active && wrap) begin
            next_exf = ~ext_event_flag;
        end else if (trig_flag) begin
            next_exf = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_two_control <= RESET_BYTE;
        end else begin
            if (wr_ctl) begin
                timer_two_control[5:0] <= bus.wdata[5:0];
            end
            timer_two_control[BIT_OVF] <= next_ovf;
            timer_two_control[BIT_EXF] <= next_exf;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_two_mode <= 2'h0;
        end else if (wr_mod) begin
            timer_two_mode <= bus.wdata[1:0] & MODE_MASK;
        end
    end

    // event flag toggling in up/down mode must not interrupt
    assign timer_irq = overflow_flag || (ext_event_flag && !updown_active);

    // ------------------------------------------------------------
    // clock out and baud ticks
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_out <= 1'b0;
        end else if (mode == TT_CLKOUT && wrap) begin
            clk_out <= ~clk_out;
        end
    end

    logic baud_wrap;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            baud_wrap <= 1'b0;
        end else begin
            baud_wrap <= wrap && (mode == TT_BAUD || mode == TT_CLKOUT);
        end
    end

    always_comb begin
        link.pin_out = clk_out;
        link.pin_oe = clock_out_enable && !count_source_select;
        link.rx_baud_tick = baud_wrap && rx_baud_select;
        link.tx_baud_tick = baud_wrap && tx_baud_select;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= RESET_BYTE;
        end else if (bus.rd) begin
            if (bus.addr == ADDR_CONTROL) begin
                rdata <= timer_two_control;
            end else if (bus.addr == ADDR_MODE) begin
                rdata <= {6'h00, timer_two_mode};
            end else if (bus.addr == ADDR_RCAP_LOW) begin
                rdata <= reload_capture[7:0];
            end else if (bus.addr == ADDR_RCAP_HIGH) begin
                rdata <= reload_capture[15:8];
            end else if (bus.addr == ADDR_COUNT_LOW) begin
                rdata <= count[7:0];
            end else if (bus.addr == ADDR_COUNT_HIGH) begin
                rdata <= count[15:8];
            end else begin
                rdata <= RESET_BYTE;
            end
        end else begin
            rdata <= RESET_BYTE;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_STOP_HOLDS: assert property (!run_control && !bus.wr |=> count == $past(count))
        else $error("count moved while stopped");
    AST_OVF_SETS: assert property (ovf_set |=> overflow_flag)
        else $error("overflow flag not set");
    AST_BAUD_NO_OVF: assert property (baud_any && !overflow_flag && !wr_ctl |=> !overflow_flag)
        else $error("overflow flag set in baud mode");
    AST_TRIG_FLAG: assert property (trig_flag |=> ext_event_flag)
        else $error("event flag missed");
    AST_CAPTURE: assert property (trig_capture |=> reload_capture == $past(count))
        else $error("capture failed");
    AST_RELOAD: assert property (wrap_up && mode == TT_RELOAD && !wr_cl && !wr_ch |=>
        count == $past(reload_capture))
        else $error("reload failed");
    AST_TRIG_RELOAD: assert property (trig_reload && !wr_cl && !wr_ch |=> count == $past(reload_capture))
        else $error("trigger reload failed");
    AST_CLK_TOGGLE: assert property (mode == TT_CLKOUT && wrap |=> link.pin_out != $past(link.pin_out))
        else $error("clock pin did not toggle");
    AST_UNDERFLOW: assert property (wrap_down && !wr_cl && !wr_ch |=> count == COUNT_MAX)
        else $error("underflow load failed");
    AST_TOGGLE: assert property (updown_active && wrap |=> ext_event_flag != $past(ext_event_flag))
        else $error("event flag did not toggle");
    AST_PIN_OE: assert property (link.pin_oe == (clock_out_enable && !count_source_select))
        else $error("pin enable wrong");
    AST_IRQ: assert property (overflow_flag |-> timer_irq)
        else $error("irq missing");
    AST_FLAG_STICKY: assert property (overflow_flag && !wr_ctl |=> overflow_flag)
        else $error("flag cleared by itself");

    COV_CAPTURE: cover property (trig_capture);
    COV_UNDERFLOW: cover property (wrap_down);
    COV_CLKOUT: cover property (mode == TT_CLKOUT && wrap);
    COV_BAUD: cover property (link.tx_baud_tick);
    COV_TRIG_RELOAD: cover property (trig_reload);
endmodule
`default_nettype wire

// ---- design/tt_pkg.sv ----
// package: register map, field positions and shared types of timer two
package tt_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_MODE = 8'hc9;
    localparam logic [7:0] ADDR_RCAP_LOW = 8'hca;
    localparam logic [7:0] ADDR_RCAP_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    localparam int BIT_OVF = 7;
    localparam int BIT_EXF = 6;
    localparam int BIT_RCLK = 5;
    localparam int BIT_TX_BAUD_SELECT = 4;
    localparam int BIT_EXEN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CSRC = 1;
    localparam int BIT_CAP = 0;
    localparam int BIT_OE = 1;
    localparam int BIT_UPDOWN_ENABLE = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] MODE_MASK = 2'h3;

    typedef enum logic [2:0] {
        TT_STOP = 3'b000,
        TT_CAPTURE = 3'b001,
        TT_RELOAD = 3'b010,
        TT_BAUD = 3'b011,
        TT_CLKOUT = 3'b100
    } tt_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tt_bus_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
        logic rx_baud_tick;
        logic tx_baud_tick;
    } tt_link_t;
endpackage

// ---- design/tt_edge_sync.sv ----
// module: two-flop synchroniser with falling-edge detector for a pin
`timescale 1ns/1ps
`default_nettype none
module tt_edge_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign fall = prev & ~sync;
endmodule
`default_nettype wire

// ---- dv/tt_pins_model.sv ----
// pin partner: external count source and trigger pin
`timescale 1ns/1ps
`default_nettype none
module tt_pins_model (
    input wire logic mclk,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic count_pin_in,
    output logic trigger_pin
);
    logic drv = 1'b1;
    // count pin follows the device while it drives the pin
    assign count_pin_in = pin_oe ? pin_out : drv;
    initial trigger_pin = 1'b1;
    // pulses kept well below half the system clock
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk) drv <= 1'b0;
            repeat (4) @(posedge mclk);
            drv <= 1'b1;
            repeat (4) @(posedge mclk);
        end
    endtask
    task automatic set_trig(input logic v);
        @(posedge mclk) trigger_pin <= v;
        repeat (5) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/timer_two_capture_reload_baud_tb_top.sv ----
// testbench: register, capture, reload, baud, updown and clock-out checks
`timescale 1ns/1ps
`default_nettype none
module timer_two_capture_reload_baud_tb_top;
    import tt_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    tt_bus_t bus = '0;
    logic [7:0] rdata;
    logic count_pin_in;
    logic trigger_pin;
    tt_link_t link;
    logic timer_irq;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] v;
    always #25 mclk = ~mclk;
    tt_timer DUT (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .count_pin_in(count_pin_in),
        .trigger_pin(trigger_pin), .link(link), .timer_irq(timer_irq));
    tt_pins_model PINS (.mclk(mclk), .pin_out(link.pin_out), .pin_oe(link.pin_oe),
        .count_pin_in(count_pin_in), .trigger_pin(trigger_pin));
    task automatic print_verdict();
        $display("counts: checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic load(input logic [15:0] cnt, input logic [15:0] rc);
        wr(ADDR_COUNT_LOW, cnt[7:0]);
        wr(ADDR_COUNT_HIGH, cnt[15:8]);
        wr(ADDR_RCAP_LOW, rc[7:0]);
        wr(ADDR_RCAP_HIGH, rc[15:8]);
    endtask
    task automatic t_reset();
        for (int a = 8'hc8; a <= 8'hce; a++) begin
            rd(8'(a), v);
            chk("reset reg", {8'h00, v}, 16'h0000);
        end
        wr(ADDR_MODE, 8'hff);
        rd(ADDR_MODE, v);
        chk("mode bits", {8'h00, v}, 16'h0003);
        wr(ADDR_MODE, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_reload();
        logic [7:0] w;
        load(16'hfff0, 16'h1234);
        wr(ADDR_CONTROL, 8'h04);
        repeat (30) @(posedge mclk);
        rd(ADDR_CONTROL, v);
        chk("ovf set", {8'h00, v}, 16'h0084);
        wr(ADDR_CONTROL, 8'h80);
        rd(ADDR_COUNT_HIGH, v);
        chk("reload high", {8'h00, v}, 16'h0012);
        rd(ADDR_COUNT_LOW, v);
        repeat (8) @(posedge mclk);
        rd(ADDR_COUNT_LOW, w);
        chk("stopped", {8'h00, w}, {8'h00, v});
        rd(ADDR_CONTROL, v);
        chk("ovf flag", {8'h00, v}, 16'h0080);
        chk("irq ovf", {15'h0, timer_irq}, 16'h0001);
        $display("test reload done");
    endtask
    task automatic t_capture();
        load(16'h5600, 16'h0000);
        wr(ADDR_CONTROL, 8'h0d);
        PINS.set_trig(1'b0);
        rd(ADDR_CONTROL, v);
        chk("capture flags", {8'h00, v}, 16'h004d);
        chk("irq exf", {15'h0, timer_irq}, 16'h0001);
        wr(ADDR_CONTROL, 8'h00);
        PINS.set_trig(1'b1);
        rd(ADDR_RCAP_HIGH, v);
        chk("captured", {8'h00, v}, 16'h0056);
        chk("irq clear", {15'h0, timer_irq}, 16'h0000);
        $display("test capture done");
    endtask
    task automatic t_trig_reload();
        load(16'h0000, 16'h4000);
        wr(ADDR_CONTROL, 8'h0c);
        PINS.set_trig(1'b0);
        rd(ADDR_CONTROL, v);
        chk("trig flags", {8'h00, v}, 16'h004c);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_HIGH, v);
        chk("trig reload", {8'h00, v}, 16'h0040);
        PINS.set_trig(1'b1);
        $display("test trigger reload done");
    endtask
    task automatic t_counter();
        load(16'h0000, 16'h0000);
        wr(ADDR_CONTROL, 8'h06);
        PINS.pulse(5);
        repeat (6) @(posedge mclk);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LOW, v);
        chk("ext count", {8'h00, v}, 16'h0005);
        $display("test counter done");
    endtask
    task automatic t_baud();
        int tx;
        int rx;
        tx = 0;
        rx = 0;
        load(16'hfff0, 16'hfff0);
        wr(ADDR_CONTROL, 8'h1c);
        fork
            PINS.set_trig(1'b0);
            repeat (64) begin
                @(posedge mclk) #1;
                tx += link.tx_baud_tick;
                rx += link.rx_baud_tick;
            end
        join
        chk("tx ticks", 16'(tx), 16'h0004);
        chk("rx ticks", 16'(rx), 16'h0000);
        rd(ADDR_CONTROL, v);
        chk("baud flags", {8'h00, v}, 16'h005c);
        wr(ADDR_CONTROL, 8'h00);
        PINS.set_trig(1'b1);
        $display("test baud done");
    endtask
    task automatic t_down();
        PINS.set_trig(1'b0);
        wr(ADDR_MODE, 8'h01);
        load(16'h1003, 16'h1000);
        wr(ADDR_CONTROL, 8'h04);
        repeat (20) @(posedge mclk);
        rd(ADDR_CONTROL, v);
        chk("down flags", {8'h00, v}, 16'h00c4);
        wr(ADDR_CONTROL, 8'h44);
        repeat (2) @(posedge mclk);
        #1;
        chk("exf silent", {15'h0, timer_irq}, 16'h0000);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_HIGH, v);
        chk("underflow load", {8'h00, v}, 16'h00ff);
        wr(ADDR_MODE, 8'h00);
        PINS.set_trig(1'b1);
        $display("test updown done");
    endtask
    task automatic t_clkout();
        int tg;
        logic last;
        tg = 0;
        wr(ADDR_MODE, 8'h02);
        load(16'hfffc, 16'hfffc);
        wr(ADDR_CONTROL, 8'h04);
        #1 last = link.pin_out;
        chk("pin driven", {15'h0, link.pin_oe}, 16'h0001);
        repeat (40) begin
            @(posedge mclk) #1;
            tg += int'(link.pin_out != last);
            last = link.pin_out;
        end
        chk("toggles", 16'(tg), 16'h000a);
        rd(ADDR_CONTROL, v);
        chk("clkout ovf", {8'h00, v}, 16'h0084);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_MODE, 8'h00);
        #1;
        chk("pin released", {15'h0, link.pin_oe}, 16'h0000);
        $display("test clkout done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_reload();
        t_capture();
        t_trig_reload();
        t_counter();
        t_baud();
        t_down();
        t_clkout();
        print_verdict();
    end
endmodule
`default_nettype wire
